// ==== pfc_defs.svh ====
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define CLK_HZ 200000000
`define SW_FREQ_HZ 100000
`define SW_PERIOD_CYC (`CLK_HZ / `SW_FREQ_HZ)
`define SW_HALF_CYC (`SW_PERIOD_CYC / 2)
`define CNT_W 12

`define DLY_120_CYC (`SW_PERIOD_CYC / 3)
`define DLY_180_CYC (`SW_PERIOD_CYC / 2)
`define DLY_240_CYC ((2 * `SW_PERIOD_CYC) / 3)

`define PULSE_NS 100
`define PULSE_CYC ((`PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`define STARTUP_US 1000
`define STARTUP_CYC (`STARTUP_US * (`CLK_HZ / 1000000))
`define STARTUP_W 18

`define MAINS_HZ 50
`define LUT_LEN 32
`define LUT_IDX_W 5
`define LUT_STEP_CYC (`CLK_HZ / (2 * `MAINS_HZ * `LUT_LEN))
`define LUT_STEP_W 17

`define IN_CMP_A 0
`define IN_CMP_B 1
`define IN_ENABLE 2
`define IN_SYNC_RISE 3
`define IN_SYNC_FALL 4
`define IN_ZERO_CROSS 5
`define IN_FAULT 6
`define IN_TWO_CH 7
`define IN_COUNT 8

`define SLV1_ON 0
`define SLV1_OFF 1
`define SLV2_ON 2
`define SLV2_OFF 3

`endif

// ==== pfc_pkg.sv ====
package pfc_pkg;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_SOFT = 2'h1,
        S_RUN = 2'h3,
        S_FAULT = 2'h2
    } run_state_t;

    typedef struct packed {
        logic s2_off;
        logic s2_on;
        logic s1_off;
        logic s1_on;
    } slave_pulse_t;

endpackage : pfc_pkg

// ==== pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= pin;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~prev;
    assign fall = ~stable & prev;
endmodule : pin_sync

// ==== phase_delay.sv ====
`timescale 1ns/10ps
`include "pfc_defs.svh"
module phase_delay (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic start,
    input wire logic [`CNT_W-1:0] delay,
    output logic pulse
);
    localparam logic [`CNT_W-1:0] PULSE_LEN = `CNT_W'(`PULSE_CYC);

    logic busy;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] width;
    logic next_busy;
    logic [`CNT_W-1:0] next_cnt;
    logic [`CNT_W-1:0] next_width;

    // A new start restarts the delay; the previous one cannot still be
    // pending since every delay is shorter than one switching period.
    always_comb begin
        next_busy = busy;
        next_cnt = cnt;
        next_width = (width != '0) ? width - `CNT_W'(1) : width;
        if (clear) begin
            next_busy = 1'b0;
            next_cnt = '0;
            next_width = '0;
        end else if (start) begin
            next_busy = 1'b1;
            next_cnt = (delay > `CNT_W'(1)) ? delay - `CNT_W'(1) : '0;
        end else if (busy) begin
            if (cnt == '0) begin
                next_busy = 1'b0;
                next_width = PULSE_LEN;
            end else begin
                next_cnt = cnt - `CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            cnt <= '0;
            width <= '0;
        end else begin
            busy <= next_busy;
            cnt <= next_cnt;
            width <= next_width;
        end
    end

    assign pulse = (width != '0);
endmodule : phase_delay

// ==== pfc_interleave.sv ====
`timescale 1ns/10ps
`include "pfc_defs.svh"
// Notes on behaviour
// - Master channel switching drive on dedicated output
// - Half-period-high square wave at switching frequency
// - Returned switching clock gates master commutations
// - Sync rise starts slave turn-on timing
// - Sync fall starts slave turn-off timing
// - Slave one on: 120 or 180 degrees
// - Slave one off: 120 or 180 degrees
// - Slave two on delayed 240 degrees
// - Slave two off delayed 240 degrees
// - Fault status high normally, low in fault
// - Startup done low only after start-up
// - Mains square-wave rising edge marks zero crossing
// - Master drive formed from both duty comparators
// - Sine reference table restarts at zero crossing
module pfc_interleave #(
    parameter int STARTUP_CYC = `STARTUP_CYC,
    parameter int LUT_STEP_CYC = `LUT_STEP_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic DUTY_CMP_A_IN,
    input wire logic DUTY_CMP_B_IN,
    input wire logic ENABLE_IN,
    input wire logic SYNC_RISE_IN,
    input wire logic SYNC_FALL_IN,
    input wire logic MAINS_ZERO_CROSS_IN,
    input wire logic FAULT_DETECT_IN,
    input wire logic TWO_CHANNEL_IN,
    output logic MASTER_PWM_OUT,
    output logic SW_CLOCK_OUT,
    output logic SLAVE1_ON_PULSE,
    output logic SLAVE1_OFF_PULSE,
    output logic SLAVE2_ON_PULSE,
    output logic SLAVE2_OFF_PULSE,
    output logic FAULT_STATUS_OUT,
    output logic STARTUP_DONE_N,
    output logic SIN_REF_OUT
);
    localparam logic [`CNT_W-1:0] PERIOD_LAST = `CNT_W'(`SW_PERIOD_CYC - 1);
    localparam logic [`CNT_W-1:0] HALF = `CNT_W'(`SW_HALF_CYC);
    localparam logic [`CNT_W-1:0] DLY_120 = `CNT_W'(`DLY_120_CYC);
    localparam logic [`CNT_W-1:0] DLY_180 = `CNT_W'(`DLY_180_CYC);
    localparam logic [`CNT_W-1:0] DLY_240 = `CNT_W'(`DLY_240_CYC);
    localparam logic [`STARTUP_W-1:0] STARTUP_LAST = `STARTUP_W'(STARTUP_CYC - 1);
    localparam logic [`LUT_STEP_W-1:0] STEP_LAST = `LUT_STEP_W'(LUT_STEP_CYC - 1);
    localparam logic [`LUT_IDX_W-1:0] IDX_LAST = `LUT_IDX_W'(`LUT_LEN - 1);

    // Half-sine table, mirrored about its middle
    function automatic logic [7:0] sine_at(input logic [`LUT_IDX_W-1:0] idx);
        logic [3:0] q;
        q = idx[4] ? ~idx[3:0] : idx[3:0];
        case (q)
            4'h0: sine_at = 8'h0c;
            4'h1: sine_at = 8'h25;
            4'h2: sine_at = 8'h3e;
            4'h3: sine_at = 8'h56;
            4'h4: sine_at = 8'h6d;
            4'h5: sine_at = 8'h83;
            4'h6: sine_at = 8'h98;
            4'h7: sine_at = 8'hab;
            4'h8: sine_at = 8'hbd;
            4'h9: sine_at = 8'hcd;
            4'ha: sine_at = 8'hdb;
            4'hb: sine_at = 8'he7;
            4'hc: sine_at = 8'hf0;
            4'hd: sine_at = 8'hf7;
            4'he: sine_at = 8'hfc;
            default: sine_at = 8'hff;
        endcase
    endfunction : sine_at

    logic [`IN_COUNT-1:0] pin_raw;
    logic [`IN_COUNT-1:0] pin_lvl;
    logic [`IN_COUNT-1:0] pin_rise;
    logic [`IN_COUNT-1:0] pin_fall;

    assign pin_raw = {TWO_CHANNEL_IN, FAULT_DETECT_IN, MAINS_ZERO_CROSS_IN, SYNC_FALL_IN,
                      SYNC_RISE_IN, ENABLE_IN, DUTY_CMP_B_IN, DUTY_CMP_A_IN};

    pin_sync #(
        .W(`IN_COUNT)
    ) u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .pin(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic fault;
    logic two_ch;
    assign fault = pin_lvl[`IN_FAULT];
    assign two_ch = pin_lvl[`IN_TWO_CH];

    // Run state and start-up
    pfc_pkg::run_state_t state;
    pfc_pkg::run_state_t next_state;
    logic [`STARTUP_W-1:0] su_cnt;
    logic [`STARTUP_W-1:0] next_su_cnt;
    logic active;

    always_comb begin
        next_state = state;
        next_su_cnt = su_cnt;
        case (state)
            pfc_pkg::S_IDLE: begin
                next_su_cnt = '0;
                if (!fault) begin
                    next_state = pfc_pkg::S_SOFT;
                end
            end
            pfc_pkg::S_SOFT: begin
                if (su_cnt == STARTUP_LAST) begin
                    next_state = pfc_pkg::S_RUN;
                end else begin
                    next_su_cnt = su_cnt + `STARTUP_W'(1);
                end
            end
            pfc_pkg::S_RUN: begin
                next_su_cnt = '0;
            end
            pfc_pkg::S_FAULT: begin
                // Start-up begins again once the fault has gone
                next_su_cnt = '0;
                if (!fault) begin
                    next_state = pfc_pkg::S_IDLE;
                end
            end
            default: begin
                next_state = pfc_pkg::S_IDLE;
                next_su_cnt = '0;
            end
        endcase
        if (fault) begin
            next_state = pfc_pkg::S_FAULT;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= pfc_pkg::S_IDLE;
            su_cnt <= '0;
        end else begin
            state <= next_state;
            su_cnt <= next_su_cnt;
        end
    end

    assign active = (state == pfc_pkg::S_SOFT) || (state == pfc_pkg::S_RUN);

    // Switching clock and master drive
    logic [`CNT_W-1:0] sw_cnt;
    logic [`CNT_W-1:0] next_sw_cnt;
    logic sw_clk;
    logic next_sw_clk;
    logic armed;
    logic next_armed;
    logic master;
    logic next_master;
    logic duty_on;

    assign duty_on = pin_lvl[`IN_CMP_A] & pin_lvl[`IN_CMP_B];

    always_comb begin
        next_sw_cnt = (sw_cnt == PERIOD_LAST) ? '0 : sw_cnt + `CNT_W'(1);
        next_sw_clk = (next_sw_cnt < HALF);
        next_armed = armed;
        // One turn-on per returned clock period; a falling clock or a
        // dropped enable forces the master off, so comparator chatter
        // cannot add extra edges.
        if (pin_rise[`IN_ENABLE]) begin
            next_armed = 1'b1;
        end else if (master && !duty_on) begin
            next_armed = 1'b0;
        end
        next_master = active && pin_lvl[`IN_ENABLE] && duty_on && (master || armed);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sw_cnt <= '0;
            sw_clk <= 1'b0;
            armed <= 1'b0;
            master <= 1'b0;
        end else begin
            sw_cnt <= next_sw_cnt;
            sw_clk <= next_sw_clk;
            armed <= next_armed;
            master <= next_master;
        end
    end

    // Interleaving of the slave channels
    logic [3:0] tmr_start;
    logic [3:0] tmr_pulse;
    logic [`CNT_W-1:0] tmr_delay [4];
    logic [`CNT_W-1:0] slave1_delay;

    assign slave1_delay = two_ch ? DLY_180 : DLY_120;
    assign tmr_delay[`SLV1_ON] = slave1_delay;
    assign tmr_delay[`SLV1_OFF] = slave1_delay;
    assign tmr_delay[`SLV2_ON] = DLY_240;
    assign tmr_delay[`SLV2_OFF] = DLY_240;

    // The drive is looped back by the board onto both sync pins
    assign tmr_start[`SLV1_ON] = active && pin_rise[`IN_SYNC_RISE];
    assign tmr_start[`SLV1_OFF] = active && pin_fall[`IN_SYNC_FALL];
    assign tmr_start[`SLV2_ON] = active && !two_ch && pin_rise[`IN_SYNC_RISE];
    assign tmr_start[`SLV2_OFF] = active && !two_ch && pin_fall[`IN_SYNC_FALL];

    for (genvar i = 0; i < 4; i++) begin : g_tmr
        phase_delay u_dly (
            .clk(CLK),
            .reset_n(RESET_N),
            .clear(!active),
            .start(tmr_start[i]),
            .delay(tmr_delay[i]),
            .pulse(tmr_pulse[i])
        );
    end

    // Pulses drive external set/reset flip-flops
    pfc_pkg::slave_pulse_t pulses;
    pfc_pkg::slave_pulse_t next_pulses;

    always_comb begin
        next_pulses.s1_on = active && tmr_pulse[`SLV1_ON];
        next_pulses.s1_off = active && tmr_pulse[`SLV1_OFF];
        next_pulses.s2_on = active && !two_ch && tmr_pulse[`SLV2_ON];
        next_pulses.s2_off = active && !two_ch && tmr_pulse[`SLV2_OFF];
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pulses <= '0;
        end else begin
            pulses <= next_pulses;
        end
    end

    // Sine reference, restarted at each mains zero crossing
    logic [`LUT_IDX_W-1:0] lut_idx;
    logic [`LUT_IDX_W-1:0] next_lut_idx;
    logic [`LUT_STEP_W-1:0] step_cnt;
    logic [`LUT_STEP_W-1:0] next_step_cnt;
    logic [7:0] carrier;
    logic [7:0] next_carrier;
    logic sin_ref;
    logic next_sin_ref;

    always_comb begin
        next_lut_idx = lut_idx;
        next_step_cnt = step_cnt + `LUT_STEP_W'(1);
        next_carrier = carrier + 8'h01;
        if (pin_rise[`IN_ZERO_CROSS]) begin
            next_lut_idx = '0;
            next_step_cnt = '0;
        end else if (step_cnt == STEP_LAST) begin
            next_step_cnt = '0;
            // Holds at the end if the next crossing comes late
            if (lut_idx != IDX_LAST) begin
                next_lut_idx = lut_idx + `LUT_IDX_W'(1);
            end
        end
        next_sin_ref = active && (carrier < sine_at(lut_idx));
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lut_idx <= '0;
            step_cnt <= '0;
            carrier <= '0;
            sin_ref <= 1'b0;
        end else begin
            lut_idx <= next_lut_idx;
            step_cnt <= next_step_cnt;
            carrier <= next_carrier;
            sin_ref <= next_sin_ref;
        end
    end

    // Status outputs
    logic fault_status;
    logic done_n;
    logic next_fault_status;
    logic next_done_n;

    always_comb begin
        next_fault_status = (next_state != pfc_pkg::S_FAULT);
        next_done_n = (next_state != pfc_pkg::S_RUN);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fault_status <= 1'b1;
            done_n <= 1'b1;
        end else begin
            fault_status <= next_fault_status;
            done_n <= next_done_n;
        end
    end

    assign MASTER_PWM_OUT = master;
    assign SW_CLOCK_OUT = sw_clk;
    assign SLAVE1_ON_PULSE = pulses.s1_on;
    assign SLAVE1_OFF_PULSE = pulses.s1_off;
    assign SLAVE2_ON_PULSE = pulses.s2_on;
    assign SLAVE2_OFF_PULSE = pulses.s2_off;
    assign FAULT_STATUS_OUT = fault_status;
    assign STARTUP_DONE_N = done_n;
    assign SIN_REF_OUT = sin_ref;
endmodule : pfc_interleave

// ==== pfc_interleave_checker.sv ====
`timescale 1ns/10ps
module pfc_interleave_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic DUTY_CMP_A_IN,
    input wire logic DUTY_CMP_B_IN,
    input wire logic ENABLE_IN,
    input wire logic SYNC_RISE_IN,
    input wire logic SYNC_FALL_IN,
    input wire logic FAULT_DETECT_IN,
    input wire logic TWO_CHANNEL_IN,
    input wire logic MASTER_PWM_OUT,
    input wire logic SW_CLOCK_OUT,
    input wire logic SLAVE1_ON_PULSE,
    input wire logic SLAVE1_OFF_PULSE,
    input wire logic SLAVE2_ON_PULSE,
    input wire logic SLAVE2_OFF_PULSE,
    input wire logic FAULT_STATUS_OUT,
    input wire logic STARTUP_DONE_N
);
    logic rise_q;
    logic fall_q;
    logic [11:0] since_r, since_f, hi_cnt, calm;
    logic [11:0] next_since_r, next_since_f, next_hi_cnt, next_calm;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    // Edge and calm counters saturate so long idle gaps never wrap into a false match; hi_cnt clears while the clock is low
    always_comb begin
        next_since_r = (SYNC_RISE_IN && !rise_q) ? 12'h000 : since_r + {11'h0, since_r != 12'hfff};
        next_since_f = (!SYNC_FALL_IN && fall_q) ? 12'h000 : since_f + {11'h0, since_f != 12'hfff};
        next_hi_cnt = SW_CLOCK_OUT ? hi_cnt + 12'h001 : 12'h000;
        next_calm = STARTUP_DONE_N ? 12'h000 : calm + {11'h0, calm != 12'hfff};
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            since_r <= 12'hfff;
            since_f <= 12'hfff;
            hi_cnt <= 12'h000;
            calm <= 12'h000;
        end else begin
            rise_q <= SYNC_RISE_IN;
            fall_q <= SYNC_FALL_IN;
            since_r <= next_since_r;
            since_f <= next_since_f;
            hi_cnt <= next_hi_cnt;
            calm <= next_calm;
        end
    end

    a_reset_idle: assert property ($rose(RESET_N) |-> STARTUP_DONE_N && FAULT_STATUS_OUT
        && !MASTER_PWM_OUT && !SLAVE1_ON_PULSE && !SLAVE2_OFF_PULSE) else $error("reset idle");
    a_fault_low: assert property ($rose(FAULT_DETECT_IN) |-> ##[2:4] !FAULT_STATUS_OUT)
        else $error("fault status late");
    a_fault_not_done: assert property (!FAULT_STATUS_OUT |-> STARTUP_DONE_N)
        else $error("done shown in fault");
    a_clock_half: assert property ($fell(SW_CLOCK_OUT) && calm == 12'hfff
        |-> hi_cnt == 12'h3e8) else $error("clock high time");
    a_master_gated: assert property ($rose(MASTER_PWM_OUT) |-> $past(ENABLE_IN, 3)
        && $past(DUTY_CMP_A_IN, 3) && $past(DUTY_CMP_B_IN, 3)) else $error("master ungated");
    a_slave1_on: assert property ($rose(SLAVE1_ON_PULSE) |-> TWO_CHANNEL_IN
        ? since_r inside {[12'h3ea:12'h3ee]} : since_r inside {[12'h29c:12'h2a0]})
        else $error("slave one on delay");
    a_slave1_off: assert property ($rose(SLAVE1_OFF_PULSE) |-> TWO_CHANNEL_IN
        ? since_f inside {[12'h3ea:12'h3ee]} : since_f inside {[12'h29c:12'h2a0]})
        else $error("slave one off delay");
    a_slave2_on: assert property ($rose(SLAVE2_ON_PULSE)
        |-> since_r inside {[12'h537:12'h53b]}) else $error("slave two on delay");
    a_slave2_off: assert property ($rose(SLAVE2_OFF_PULSE)
        |-> since_f inside {[12'h537:12'h53b]}) else $error("slave two off delay");
    a_slave2_quiet: assert property (TWO_CHANNEL_IN [*4]
        |-> !SLAVE2_ON_PULSE && !SLAVE2_OFF_PULSE) else $error("slave two active");
endmodule : pfc_interleave_checker

// ==== pfc_board_model.sv ====
`timescale 1ns/10ps
module pfc_board_model (
    input wire logic clk,
    input wire logic [10:0] pi_level,
    input wire logic master,
    input wire logic sw_clock,
    input wire pfc_pkg::slave_pulse_t pulses,
    output logic cmp_a,
    output logic cmp_b,
    output logic enable,
    output logic sync_rise,
    output logic sync_fall,
    output logic phase_a = 1'b0,
    output logic phase_b = 1'b0
);
    logic [10:0] ramp = 11'h000;

    // Integrator ramps up while the clock is high, down while low
    always @(posedge clk) begin
        if (sw_clock && ramp < 11'h3e8) ramp <= ramp + 11'h001;
        else if (!sw_clock && ramp != 11'h000) ramp <= ramp - 11'h001;
        if (pulses.s1_on) phase_a <= 1'b1;
        if (pulses.s1_off) phase_a <= 1'b0;
        if (pulses.s2_on) phase_b <= 1'b1;
        if (pulses.s2_off) phase_b <= 1'b0;
    end

    assign cmp_a = pi_level > ramp;
    assign cmp_b = pi_level > ramp;
    assign enable = sw_clock;
    assign sync_rise = master;
    assign sync_fall = master;
endmodule : pfc_board_model

// ==== test_pfc_interleave.sv ====
`timescale 1ns/10ps
module test_pfc_interleave;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic fault_in = 1'b0;
    logic two_ch = 1'b0;
    logic zc = 1'b0;
    logic [10:0] pi_level = 11'h000;
    logic cmp_a, cmp_b, enable, sync_rise, sync_fall, phase_a, phase_b;
    logic master, sw_clock, sin_ref, fault_ok, done_n;
    wire pfc_pkg::slave_pulse_t pulses;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int sr = 0;
    int sf = 0;
    int s2_count = 0;
    int lat [4];
    logic [3:0] prev_p = 4'h0;
    logic prev_r = 1'b0;
    logic prev_f = 1'b0;

    always #2.5 CLK = ~CLK;

    pfc_interleave #(.STARTUP_CYC(50), .LUT_STEP_CYC(20)) i_dut (
        .CLK(CLK), .RESET_N(RESET_N), .DUTY_CMP_A_IN(cmp_a), .DUTY_CMP_B_IN(cmp_b),
        .ENABLE_IN(enable), .SYNC_RISE_IN(sync_rise), .SYNC_FALL_IN(sync_fall),
        .MAINS_ZERO_CROSS_IN(zc), .FAULT_DETECT_IN(fault_in), .TWO_CHANNEL_IN(two_ch),
        .MASTER_PWM_OUT(master), .SW_CLOCK_OUT(sw_clock), .SLAVE1_ON_PULSE(pulses.s1_on),
        .SLAVE1_OFF_PULSE(pulses.s1_off), .SLAVE2_ON_PULSE(pulses.s2_on),
        .SLAVE2_OFF_PULSE(pulses.s2_off), .FAULT_STATUS_OUT(fault_ok),
        .STARTUP_DONE_N(done_n), .SIN_REF_OUT(sin_ref));

    pfc_board_model i_board (.clk(CLK), .pi_level(pi_level), .master(master),
        .sw_clock(sw_clock), .pulses(pulses), .cmp_a(cmp_a), .cmp_b(cmp_b),
        .enable(enable), .sync_rise(sync_rise), .sync_fall(sync_fall),
        .phase_a(phase_a), .phase_b(phase_b));

    // Latency seen from the last sync edge; sampled mid-cycle, away from the launch edge
    always @(negedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            if (pulses[i] && !prev_p[i]) begin
                lat[i] = i[0] ? sf : sr;
                s2_count += i / 2;
            end
        end
        prev_p = pulses;
        sr = (sync_rise && !prev_r) ? 0 : sr + 1;
        sf = (!sync_fall && prev_f) ? 0 : sf + 1;
        prev_r = sync_rise;
        prev_f = sync_fall;
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : step

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic lat_check(input int i, input int d);
        check(lat[i] >= d + 2 && lat[i] <= d + 6, 1'b1);
    endtask : lat_check

    task automatic wait_done;
        int n;
        n = 0;
        while (done_n !== 1'b0 && n < 200) begin
            step(1);
            n++;
        end
        check(n > 40, 1'b1);
        check(done_n, 1'b0);
        check(fault_ok, 1'b1);
    endtask : wait_done

    task automatic t_three;
        int hi;
        int mh;
        int pa;
        int pb;
        lat = '{-1, -1, -1, -1};
        pi_level = 11'h1f4;
        step(6000);
        lat_check(0, 666);
        lat_check(1, 666);
        lat_check(2, 1333);
        lat_check(3, 1333);
        hi = 0;
        mh = 0;
        pa = 0;
        pb = 0;
        // One full switching period; slave drives copy the master's on time
        repeat (2000) begin
            step(1);
            hi += (sw_clock === 1'b1);
            mh += (master === 1'b1);
            pa += (phase_a === 1'b1);
            pb += (phase_b === 1'b1);
        end
        check(hi, 1000);
        check(mh > 0, 1'b1);
        check(pa, mh);
        check(pb, mh);
    endtask : t_three

    task automatic zc_count(output int c);
        zc = 1'b1;
        c = 0;
        repeat (300) begin
            step(1);
            c += (sin_ref === 1'b1);
        end
        zc = 1'b0;
        step(2260);
    endtask : zc_count

    task automatic t_mains;
        int a;
        int b;
        zc_count(a);
        zc_count(b);
        check(a > 0, 1'b1);
        check(b, a);
    endtask : t_mains

    task automatic t_two;
        int s2;
        pi_level = 11'h000;
        step(2500);
        two_ch = 1'b1;
        s2 = s2_count;
        lat = '{-1, -1, -1, -1};
        pi_level = 11'h1f4;
        step(6000);
        lat_check(0, 1000);
        lat_check(1, 1000);
        check(s2_count, s2);
    endtask : t_two

    task automatic t_fault;
        fault_in = 1'b1;
        step(5);
        check(fault_ok, 1'b0);
        check(done_n, 1'b1);
        step(10);
        check(master, 1'b0);
        fault_in = 1'b0;
        wait_done();
    endtask : t_fault

    task automatic t_reset;
        RESET_N = 1'b0;
        step(2);
        check(pulses, 4'h0);
        check(done_n, 1'b1);
        check(master, 1'b0);
        RESET_N = 1'b1;
        wait_done();
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        step(2);
        RESET_N = 1'b1;
        check(done_n, 1'b1);
        wait_done();
        t_three();
        t_mains();
        t_two();
        t_fault();
        t_reset();
        final_report();
    end
endmodule : test_pfc_interleave

bind pfc_interleave pfc_interleave_checker i_chk (
    .CLK(CLK), .RESET_N(RESET_N), .DUTY_CMP_A_IN(DUTY_CMP_A_IN),
    .DUTY_CMP_B_IN(DUTY_CMP_B_IN), .ENABLE_IN(ENABLE_IN), .SYNC_RISE_IN(SYNC_RISE_IN),
    .SYNC_FALL_IN(SYNC_FALL_IN), .FAULT_DETECT_IN(FAULT_DETECT_IN),
    .TWO_CHANNEL_IN(TWO_CHANNEL_IN), .MASTER_PWM_OUT(MASTER_PWM_OUT),
    .SW_CLOCK_OUT(SW_CLOCK_OUT), .SLAVE1_ON_PULSE(SLAVE1_ON_PULSE),
    .SLAVE1_OFF_PULSE(SLAVE1_OFF_PULSE), .SLAVE2_ON_PULSE(SLAVE2_ON_PULSE),
    .SLAVE2_OFF_PULSE(SLAVE2_OFF_PULSE), .FAULT_STATUS_OUT(FAULT_STATUS_OUT),
    .STARTUP_DONE_N(STARTUP_DONE_N));
